//--- hdl/mpce_host.sv
// host sequencer for multi-plane program, copy, erase, id and status
`timescale 1ns/1ps
module mpce_host #(
  parameter int BLOCK_W = 12,
  parameter int PAGE_W = 7,
  parameter int COL_W = 14,
  parameter int MAX_LEN = mpce_pkg::PAGE_BYTES
) (
  input logic ref_clk,
  input logic reset_n,
  input logic op_start,
  input mpce_pkg::mpce_op_t op_kind,
  input logic op_multi,
  input logic op_final,
  input logic [BLOCK_W-1:0] op_block_a,
  input logic [BLOCK_W-1:0] op_block_b,
  input logic [PAGE_W-1:0] op_page,
  input logic [COL_W-1:0] op_column,
  input logic [13:0] op_len,
  input logic wp_req,
  output logic op_ready,
  output logic op_done,
  output logic op_refused,
  input logic [7:0] wr_data,
  input logic wr_valid,
  output logic wr_ready,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic [2:0] rd_index,
  output logic [7:0] status_byte,
  output logic any_fail,
  output logic [1:0] cur_fail,
  output logic [1:0] prev_fail,
  output logic dev_ready,
  output logic cache_ready,
  output logic not_protected,
  output logic status_incoherent,
  output logic prog_open,
  output logic copy_open,
  output logic nand_ce_n,
  output logic nand_cle,
  output logic nand_ale,
  output logic nand_we_n,
  output logic nand_re_n,
  output logic nand_wp_n,
  output logic [7:0] nand_io_out,
  output logic nand_io_oe,
  input logic [7:0] nand_io_in,
  input logic ready_busy_out
);
  import mpce_pkg::*;

  typedef enum logic [3:0] {ST_IDLE, ST_SETUP, ST_ADDR, ST_DATA, ST_CONF, ST_WB, ST_BUSY,
    ST_STCMD, ST_STRD, ST_IDRD, ST_DONE} mpce_state_t;

  if (BLOCK_W + PAGE_W > 24 || COL_W > 16 || PAGE_W != 7 || MAX_LEN > 16383) begin : g_chk
    $error("mpce_host: address or length parameter out of range");
  end

  mpce_state_t st_r;
  mpce_op_t op_r;
  logic multi_r, final_r, plane_r, pend_r, refused_r, done_r;
  logic prog_open_r, copy_open_r, incoh_r, ce_n_r, wp_n_r;
  logic [BLOCK_W-1:0] blk_a_r, blk_b_r, sess_a_r, sess_b_r;
  logic [PAGE_W-1:0] page_r, sess_page_r;
  logic [COL_W-1:0] col_r;
  logic [13:0] len_r, len_hold_r;
  logic [2:0] idx_r, aidx;
  logic [7:0] wb_cnt_r, status_r, last_cmd_r, rd_data_r;
  logic rd_valid_r;
  logic [2:0] rd_index_r;
  logic cyc_start, cyc_busy, cyc_done, refuse, accept, addr_last, rb_sync;
  mpce_cyc_t cyc_kind;
  logic [7:0] cyc_byte, cyc_rbyte, io_sync, setup_cmd, conf_cmd, addr_byte;
  logic [23:0] row;
  logic [15:0] col16;

  // ready/busy and io pins come from outside the clock domain
  mpce_sync #(.W(9)) u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .din({ready_busy_out, nand_io_in}),
    .dout({rb_sync, io_sync})
  );

  mpce_pin_cycle u_cyc (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .start(cyc_start),
    .kind(cyc_kind),
    .wbyte(cyc_byte),
    .io_sync(io_sync),
    .busy(cyc_busy),
    .done(cyc_done),
    .rbyte(cyc_rbyte),
    .cle(nand_cle),
    .ale(nand_ale),
    .we_n(nand_we_n),
    .re_n(nand_re_n),
    .io_out(nand_io_out),
    .io_oe(nand_io_oe)
  );

  // refusals checked at the port so the die never sees an illegal sequence
  always_comb begin
    refuse = 1'b0;
    if (prog_open_r && !(op_kind inside {OP_PROG, OP_STATUS, OP_RESET})) begin
      refuse = 1'b1;
    end
    if (copy_open_r && !(op_kind inside {OP_COPY, OP_STATUS, OP_RESET})) begin
      refuse = 1'b1;
    end
    if (op_kind == OP_PROG && !prog_open_r && op_page != '0) begin
      refuse = 1'b1;
    end
    if (op_kind == OP_PROG && prog_open_r && (op_block_a != sess_a_r ||
        op_block_b != sess_b_r || op_page != sess_page_r + 7'h01)) begin
      refuse = 1'b1;
    end
    if (op_multi && op_kind inside {OP_PROG, OP_COPY, OP_ERASE} &&
        op_block_a[0] == op_block_b[0]) begin
      refuse = 1'b1;
    end
    if (op_kind == OP_COPY && wp_req) begin
      refuse = 1'b1;
    end
    if (op_len > MAX_LEN) begin
      refuse = 1'b1;
    end
  end

  assign accept = (st_r == ST_IDLE) && op_start && !refuse;

  // latch the order on acceptance; last page always closes with 10h
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      op_r <= OP_STATUS;
      multi_r <= 1'b0;
      final_r <= 1'b0;
      blk_a_r <= '0;
      blk_b_r <= '0;
      page_r <= '0;
      col_r <= '0;
      len_hold_r <= 14'h0000;
    end else if (accept) begin
      op_r <= op_kind;
      multi_r <= op_multi;
      final_r <= op_final || (op_kind == OP_PROG && op_page == LAST_PAGE);
      blk_a_r <= op_block_a;
      blk_b_r <= op_block_b;
      page_r <= op_page;
      col_r <= op_column;
      len_hold_r <= op_len;
    end
  end

  // command bytes per phase
  always_comb begin
    case (op_r)
      OP_PROG: setup_cmd = CMD_SERIAL_IN;
      OP_COPY: setup_cmd = CMD_COPY_IN;
      OP_ERASE: setup_cmd = CMD_ERASE_SETUP;
      OP_ID: setup_cmd = CMD_ID;
      OP_RESET: setup_cmd = CMD_RESET;
      default: setup_cmd = CMD_STATUS_MP;
    endcase
    if (op_r == OP_ERASE) begin
      conf_cmd = CMD_ERASE_GO;
    end else if (multi_r && !plane_r) begin
      conf_cmd = CMD_PROG_PLANE;
    end else if (final_r) begin
      conf_cmd = CMD_PROG_FINAL;
    end else begin
      conf_cmd = CMD_PROG_CACHE;
    end
  end

  // address cycles: two column then three row bytes; erase sends row only
  assign row = 24'({plane_r ? blk_b_r : blk_a_r, page_r});
  assign col16 = 16'(col_r);
  always_comb begin
    case (op_r)
      OP_ERASE: aidx = idx_r + 3'h2;
      OP_ID: aidx = 3'h5;
      default: aidx = idx_r;
    endcase
    case (aidx)
      3'h0: addr_byte = col16[7:0];
      3'h1: addr_byte = col16[15:8];
      3'h2: addr_byte = row[7:0];
      3'h3: addr_byte = row[15:8];
      3'h4: addr_byte = row[23:16];
      default: addr_byte = ID_ADDR;
    endcase
    case (op_r)
      OP_ERASE: addr_last = (idx_r == 3'(ADDR_ERASE_N - 1));
      OP_ID: addr_last = (idx_r == 3'(ADDR_ID_N - 1));
      default: addr_last = (idx_r == 3'(ADDR_PROG_N - 1));
    endcase
  end

  // what the pin engine is asked to do in each state
  always_comb begin
    cyc_kind = CY_CMD;
    cyc_byte = setup_cmd;
    cyc_start = !pend_r && !cyc_busy;
    case (st_r)
      ST_SETUP: cyc_byte = setup_cmd;
      ST_ADDR: begin
        cyc_kind = CY_ADDR;
        cyc_byte = addr_byte;
      end
      ST_DATA: begin
        cyc_kind = CY_WDATA;
        cyc_byte = wr_data;
        cyc_start = wr_valid && wr_ready;
      end
      ST_CONF: cyc_byte = conf_cmd;
      ST_STCMD: cyc_byte = CMD_STATUS_MP;
      ST_STRD, ST_IDRD: cyc_kind = CY_READ;
      default: cyc_start = 1'b0;
    endcase
  end

  assign wr_ready = (st_r == ST_DATA) && !pend_r && !cyc_busy;

  // one byte in flight at a time
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pend_r <= 1'b0;
    end else if (cyc_start) begin
      pend_r <= 1'b1;
    end else if (cyc_done) begin
      pend_r <= 1'b0;
    end
  end

  // main sequence
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st_r <= ST_IDLE;
      plane_r <= 1'b0;
      idx_r <= 3'h0;
      len_r <= 14'h0000;
      wb_cnt_r <= 8'h00;
    end else begin
      case (st_r)
        ST_IDLE: if (accept) begin
          plane_r <= 1'b0;
          idx_r <= 3'h0;
          len_r <= op_len;
          st_r <= (op_kind == OP_STATUS) ? ST_STCMD : ST_SETUP;
        end else if (op_start) begin
          st_r <= ST_DONE;
        end
        ST_SETUP: if (cyc_done) begin
          wb_cnt_r <= 8'(WB_CYC);
          st_r <= (op_r == OP_RESET) ? ST_WB : ST_ADDR;
        end
        ST_ADDR: if (cyc_done) begin
          idx_r <= addr_last ? 3'h0 : idx_r + 3'h1;
          if (addr_last) begin
            case (op_r)
              OP_ID: st_r <= ST_IDRD;
              OP_ERASE: if (multi_r && !plane_r) begin
                plane_r <= 1'b1;
                st_r <= ST_SETUP;
              end else begin
                st_r <= ST_CONF;
              end
              default: st_r <= (len_r == 14'h0000) ? ST_CONF : ST_DATA;
            endcase
          end
        end
        ST_DATA: if (cyc_done) begin
          len_r <= len_r - 14'h0001;
          if (len_r == 14'h0001) begin
            st_r <= ST_CONF;
          end
        end
        ST_CONF: if (cyc_done) begin
          wb_cnt_r <= 8'(WB_CYC);
          st_r <= ST_WB;
        end
        // give the die time to pull busy before watching it
        ST_WB: if (wb_cnt_r == 8'h00) begin
          st_r <= ST_BUSY;
        end else begin
          wb_cnt_r <= wb_cnt_r - 8'h01;
        end
        ST_BUSY: if (rb_sync) begin
          if (op_r inside {OP_PROG, OP_COPY} && multi_r && !plane_r) begin
            plane_r <= 1'b1;
            len_r <= len_hold_r;
            st_r <= ST_SETUP;
          end else begin
            st_r <= (op_r == OP_RESET) ? ST_DONE : ST_STCMD;
          end
        end
        ST_STCMD: if (cyc_done) begin
          st_r <= ST_STRD;
        end
        ST_STRD: if (cyc_done) begin
          st_r <= ST_DONE;
        end
        ST_IDRD: if (cyc_done) begin
          idx_r <= idx_r + 3'h1;
          if (idx_r == ID_LAST) begin
            st_r <= ST_DONE;
          end
        end
        ST_DONE: st_r <= ST_IDLE;
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // session tracking; a reset drops any open session, and the paired
  // earlier page of an unfinished one may be damaged
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      prog_open_r <= 1'b0;
      copy_open_r <= 1'b0;
      sess_a_r <= '0;
      sess_b_r <= '0;
      sess_page_r <= '0;
    end else if (st_r == ST_DONE && !refused_r) begin
      case (op_r)
        OP_PROG: begin
          prog_open_r <= !final_r;
          sess_a_r <= blk_a_r;
          sess_b_r <= blk_b_r;
          sess_page_r <= page_r;
        end
        OP_COPY: copy_open_r <= !final_r;
        OP_RESET: begin
          prog_open_r <= 1'b0;
          copy_open_r <= 1'b0;
        end
        default: ;
      endcase
    end
  end

  // completion, refusal and read results
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      done_r <= 1'b0;
      refused_r <= 1'b0;
      status_r <= 8'h00;
      incoh_r <= 1'b0;
      last_cmd_r <= 8'h00;
      rd_data_r <= 8'h00;
      rd_valid_r <= 1'b0;
      rd_index_r <= 3'h0;
    end else begin
      done_r <= (st_r == ST_DONE);
      rd_valid_r <= 1'b0;
      if (st_r == ST_IDLE && op_start) begin
        refused_r <= refuse;
      end
      if (cyc_start && cyc_kind == CY_CMD && st_r != ST_STCMD) begin
        last_cmd_r <= cyc_byte;
      end
      if (st_r == ST_STRD && cyc_done) begin
        status_r <= cyc_rbyte;
        incoh_r <= (cyc_rbyte[ST_READY] != cyc_rbyte[ST_CACHE]) &&
          (last_cmd_r != CMD_PROG_CACHE);
      end
      if (st_r == ST_IDRD && cyc_done) begin
        rd_data_r <= cyc_rbyte;
        rd_valid_r <= 1'b1;
        rd_index_r <= idx_r;
      end
    end
  end

  // chip enable and write protect; protect only when nothing is open
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ce_n_r <= 1'b1;
      wp_n_r <= 1'b1;
    end else begin
      ce_n_r <= (st_r == ST_IDLE) && !accept;
      wp_n_r <= !(wp_req && st_r == ST_IDLE && !op_start && !prog_open_r &&
        !copy_open_r);
    end
  end

  assign op_ready = (st_r == ST_IDLE);
  assign op_done = done_r;
  assign op_refused = refused_r;
  assign rd_data = rd_data_r;
  assign rd_valid = rd_valid_r;
  assign rd_index = rd_index_r;
  assign status_byte = status_r;
  assign any_fail = status_r[ST_FAIL_ANY];
  assign cur_fail = {status_r[ST_P1_CUR], status_r[ST_P0_CUR]};
  assign prev_fail = {status_r[ST_P1_PREV], status_r[ST_P0_PREV]};
  assign dev_ready = status_r[ST_READY];
  assign cache_ready = status_r[ST_CACHE];
  assign not_protected = status_r[ST_UNPROT];
  assign status_incoherent = incoh_r;
  assign prog_open = prog_open_r;
  assign copy_open = copy_open_r;
  assign nand_ce_n = ce_n_r;
  assign nand_wp_n = wp_n_r;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_conf_issue;
    st_r == ST_CONF && cyc_start;
  endsequence
  sequence s_erase_go;
    st_r == ST_CONF && op_r == OP_ERASE && cyc_done;
  endsequence

  property p_block_stay;
    accept && op_kind == OP_PROG && prog_open_r |->
      op_block_a == sess_a_r && op_page == sess_page_r + 7'h01;
  endproperty
  a_block_stay: assert property (p_block_stay) else $error("block change in session");
  property p_first_page;
    accept && op_kind == OP_PROG && !prog_open_r |-> op_page == '0;
  endproperty
  a_first_page: assert property (p_first_page) else $error("session not at page 0");
  property p_last_final;
    s_conf_issue and (op_r == OP_PROG && page_r == LAST_PAGE && plane_r == multi_r) |->
      cyc_byte == CMD_PROG_FINAL;
  endproperty
  a_last_final: assert property (p_last_final) else $error("last page not 10h");
  property p_plane_split;
    accept && op_multi && op_kind inside {OP_PROG, OP_COPY, OP_ERASE} |->
      op_block_a[0] != op_block_b[0];
  endproperty
  a_plane_split: assert property (p_plane_split) else $error("same plane twice");
  property p_first_plane;
    s_conf_issue and (op_r == OP_PROG && multi_r && !plane_r) |->
      cyc_byte == CMD_PROG_PLANE;
  endproperty
  a_first_plane: assert property (p_first_plane) else $error("first plane not 11h");
  property p_lock;
    st_r == ST_IDLE && op_start && prog_open_r &&
      op_kind inside {OP_COPY, OP_ERASE, OP_ID} |=> ##1 op_done && op_refused;
  endproperty
  a_lock: assert property (p_lock) else $error("foreign op in session");
  property p_copy_wp;
    (st_r != ST_IDLE && op_r == OP_COPY) |-> nand_wp_n;
  endproperty
  a_copy_wp: assert property (p_copy_wp) else $error("write protect during copy");
  property p_no_data;
    st_r == ST_ADDR && cyc_done && addr_last && op_r == OP_COPY && len_r == 14'h0000 |=>
      st_r == ST_CONF;
  endproperty
  a_no_data: assert property (p_no_data) else $error("data cycles not skipped");
  property p_erase_wait;
    s_erase_go |=> st_r == ST_WB ##[1:40] st_r == ST_BUSY;
  endproperty
  a_erase_wait: assert property (p_erase_wait) else $error("erase busy not awaited");
  property p_after_80;
    s_conf_issue and (op_r == OP_PROG) |->
      cyc_byte inside {CMD_PROG_FINAL, CMD_PROG_PLANE, CMD_PROG_CACHE};
  endproperty
  a_after_80: assert property (p_after_80) else $error("bad command after 80h");
  property p_busy_hold;
    st_r == ST_BUSY && !rb_sync |=> st_r == ST_BUSY;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("left busy wait early");
  property p_reset_clear;
    st_r == ST_DONE && op_r == OP_RESET && !refused_r |=> !prog_open_r && !copy_open_r;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset kept session");
endmodule : mpce_host

//--- hdl/mpce_pin_cycle.sv
// one strobed byte cycle on the flash port: command, address, write or read
`timescale 1ns/1ps
module mpce_pin_cycle (
  input logic ref_clk,
  input logic reset_n,
  input logic start,
  input mpce_pkg::mpce_cyc_t kind,
  input logic [7:0] wbyte,
  input logic [7:0] io_sync,
  output logic busy,
  output logic done,
  output logic [7:0] rbyte,
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic re_n,
  output logic [7:0] io_out,
  output logic io_oe
);
  import mpce_pkg::*;

  typedef enum logic [1:0] {PH_IDLE, PH_LOW, PH_HIGH} mpce_ph_t;
  mpce_ph_t ph_r;
  logic [7:0] cnt_r;
  logic rd_r;

  if (RP_CYC > 255 || WP_CYC > 255 || WH_CYC > 255 || REH_CYC > 255) begin : g_chk
    $error("mpce_pin_cycle: strobe count too wide");
  end

  // strobe low phase, then high phase; io held across both for hold time
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ph_r <= PH_IDLE;
      cnt_r <= 8'h00;
      rd_r <= 1'b0;
      done <= 1'b0;
      rbyte <= 8'h00;
      cle <= 1'b0;
      ale <= 1'b0;
      we_n <= 1'b1;
      re_n <= 1'b1;
      io_out <= 8'h00;
      io_oe <= 1'b0;
    end else begin
      done <= 1'b0;
      case (ph_r)
        PH_IDLE: if (start) begin
          rd_r <= (kind == CY_READ);
          cle <= (kind == CY_CMD);
          ale <= (kind == CY_ADDR);
          io_out <= wbyte;
          io_oe <= (kind != CY_READ);
          we_n <= (kind == CY_READ);
          re_n <= (kind != CY_READ);
          cnt_r <= (kind == CY_READ) ? 8'(RP_CYC) : 8'(WP_CYC);
          ph_r <= PH_LOW;
        end
        PH_LOW: if (cnt_r == 8'h01) begin
          we_n <= 1'b1;
          re_n <= 1'b1;
          if (rd_r) begin
            rbyte <= io_sync; // sync latency is folded into the low time
          end
          cnt_r <= rd_r ? 8'(REH_CYC) : 8'(WH_CYC);
          ph_r <= PH_HIGH;
        end else begin
          cnt_r <= cnt_r - 8'h01;
        end
        PH_HIGH: if (cnt_r == 8'h01) begin
          cle <= 1'b0;
          ale <= 1'b0;
          io_oe <= 1'b0;
          done <= 1'b1;
          ph_r <= PH_IDLE;
        end else begin
          cnt_r <= cnt_r - 8'h01;
        end
        default: ph_r <= PH_IDLE;
      endcase
    end
  end

  assign busy = (ph_r != PH_IDLE);
endmodule : mpce_pin_cycle

//--- hdl/mpce_sync.sv
// three-flop input synchroniser, change taken once stages two and three agree
`timescale 1ns/1ps
module mpce_sync #(
  parameter int W = 9
) (
  input logic ref_clk,
  input logic reset_n,
  input logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;

  // first stage feeds only the second
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // per-bit agreement filter rejects a one-stage glitch
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
        q_r[i] <= 1'b0;
      end else if (s2_r[i] == s3_r[i]) begin
        q_r[i] <= s3_r[i];
      end
    end
  end

  assign dout = q_r;
endmodule : mpce_sync

//--- pkg/mpce_pkg.sv
// constants and types for the two-plane flash host sequencer
// What this block does
// - restart cached program when block advances
// - cached program starts page 0, 128 pages
// - close cached program with 80h then 10h
// - one block per plane, same page
// - first plane ends 11h, second 15h/10h
// - open cached program allows only own commands
// - reset mid-program may hurt paired page
// - close page copy with 8Ch then 10h
// - copy data bytes only where altered
// - hold write protect high during copy
// - two-plane copy same page, ends 10h; the code ends it with 15h when op_final is low
// - two-plane erase, two 60h, one D0h
// - abandon two-plane erase with FFh only
// - after 80h only 85h/10h/11h/15h/FFh
package mpce_pkg;
  localparam logic [7:0] CMD_SERIAL_IN = 8'h80;
  localparam logic [7:0] CMD_PROG_FINAL = 8'h10;
  localparam logic [7:0] CMD_PROG_PLANE = 8'h11;
  localparam logic [7:0] CMD_PROG_CACHE = 8'h15;
  localparam logic [7:0] CMD_COPY_IN = 8'h8C;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
  localparam logic [7:0] CMD_STATUS_MP = 8'h71;
  localparam logic [7:0] CMD_ID = 8'h90;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] ID_ADDR = 8'h00;
  localparam logic [2:0] ID_LAST = 3'h7;
  localparam logic [6:0] LAST_PAGE = 7'h7F;
  localparam int PAGE_BYTES = 8568;
  localparam int ADDR_PROG_N = 5;
  localparam int ADDR_ERASE_N = 3;
  localparam int ADDR_ID_N = 1;
  // status byte field positions
  localparam int ST_FAIL_ANY = 0;
  localparam int ST_P0_CUR = 1;
  localparam int ST_P1_CUR = 2;
  localparam int ST_P0_PREV = 3;
  localparam int ST_P1_PREV = 4;
  localparam int ST_READY = 5;
  localparam int ST_CACHE = 6;
  localparam int ST_UNPROT = 7;
  // strobe timing, least times rounded up to whole cycles
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_WP_NS = 25;
  localparam int T_WH_NS = 15;
  localparam int T_RP_NS = 25;
  localparam int T_REH_NS = 15;
  localparam int T_WB_NS = 100;
  localparam int SYNC_LAT = 3;
  localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WH_CYC = (T_WH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RP_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_LAT;
  localparam int REH_CYC = (T_REH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WB_CYC = (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [2:0] {OP_PROG, OP_COPY, OP_ERASE, OP_ID, OP_STATUS, OP_RESET} mpce_op_t;
  typedef enum logic [1:0] {CY_CMD, CY_ADDR, CY_WDATA, CY_READ} mpce_cyc_t;
endpackage : mpce_pkg

//--- verification/mpce_flash_model.sv
// behavioural two-plane flash die answering the host pins
`timescale 1ns/1ps
module mpce_flash_model #(
  parameter int BUSY_NS = 400,
  parameter logic [7:0] ID_BASE = 8'hC0 // arbitrary id pattern
) (
  input logic nand_ce_n,
  input logic nand_cle,
  input logic nand_we_n,
  input logic nand_re_n,
  input logic nand_wp_n,
  input logic [7:0] nand_io_out,
  input logic [1:0] fail_inj,
  output logic [7:0] nand_io_in,
  output logic ready_busy_out
);
  logic [7:0] cmd_r = 8'h00;
  logic [2:0] idx_r = 3'h0;
  logic [1:0] cur_r = 2'h0;
  logic [1:0] prev_r = 2'h0;
  initial nand_io_in = 8'hA5;
  initial ready_busy_out = 1'b1;
  // commands latch on strobe rise; data cycles ignored, any count taken
  always @(posedge nand_we_n) if (!nand_ce_n && nand_cle) begin
    cmd_r = nand_io_out;
    idx_r = 3'h0;
    if (nand_io_out inside {8'h10, 8'h15, 8'hD0}) begin
      prev_r = cur_r;
      cur_r = fail_inj;
    end
    if (nand_io_out inside {8'h10, 8'h11, 8'h15, 8'hD0, 8'hFF}) begin
      ready_busy_out = 1'b0;
      ready_busy_out <= #(BUSY_NS) 1'b1;
    end
  end
  // verify loop folded into one busy span, so no retry count is modelled
  always @(negedge nand_re_n) if (!nand_ce_n)
    nand_io_in = (cmd_r == 8'h90) ? ID_BASE + 8'(idx_r)
      : {nand_wp_n, ready_busy_out, ready_busy_out, prev_r, cur_r, |cur_r};
  // released bus shows the inverse so a late sample cannot pass
  always @(posedge nand_re_n) begin
    nand_io_in = ~nand_io_in;
    idx_r = idx_r + 3'h1;
  end
endmodule : mpce_flash_model

//--- verification/tb.sv
// self-checking bench for the flash host sequencer
`timescale 1ns/1ps
module tb;
  import mpce_pkg::*;
  typedef struct {mpce_op_t k; logic m, f, w; logic [11:0] a, b; logic [6:0] p;
    logic [1:0] fi; logic rf; logic [7:0] st;} mpce_row_t;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic op_start = 1'b0, op_multi = 1'b0, op_final = 1'b0, wp_req = 1'b0;
  mpce_op_t op_kind = OP_STATUS;
  logic [11:0] op_block_a = 12'h000, op_block_b = 12'h001;
  logic [6:0] op_page = 7'h00;
  logic [1:0] fail_inj = 2'h0;
  logic op_ready, op_done, op_refused, rd_valid, nand_ce_n, nand_cle, nand_we_n, nand_re_n;
  logic nand_wp_n, nand_io_oe, ready_busy_out;
  logic [7:0] rd_data, status_byte, nand_io_out, nand_io_in;
  logic [2:0] rd_index;
  logic any_fail, dev_ready, cache_ready, not_protected, status_incoherent, prog_open, copy_open;
  logic [1:0] cur_fail, prev_fail;
  logic [7:0] fields, sess;
  logic [13:0] op_len = 14'h0002;
  logic [7:0] id_seen [8];
  int mismatches = 0;
  int n_compared = 0;
  mpce_row_t rows [11] = '{
    '{OP_ERASE, 1, 0, 0, 12'h002, 12'h003, 7'h00, 2'h0, 0, 8'hE0},
    '{OP_ERASE, 1, 0, 0, 12'h002, 12'h004, 7'h00, 2'h0, 1, 8'h00},
    '{OP_PROG, 1, 0, 0, 12'h005, 12'h004, 7'h00, 2'h1, 0, 8'hE3},
    '{OP_PROG, 1, 0, 0, 12'h005, 12'h004, 7'h01, 2'h2, 0, 8'hED},
    '{OP_PROG, 1, 0, 0, 12'h005, 12'h004, 7'h03, 2'h0, 1, 8'h00},
    '{OP_ERASE, 1, 0, 0, 12'h002, 12'h003, 7'h00, 2'h0, 1, 8'h00},
    '{OP_PROG, 1, 1, 0, 12'h005, 12'h004, 7'h02, 2'h0, 0, 8'hF0},
    '{OP_STATUS, 0, 0, 0, 12'h000, 12'h001, 7'h00, 2'h0, 0, 8'hF0},
    '{OP_COPY, 0, 1, 1, 12'h006, 12'h006, 7'h00, 2'h0, 1, 8'h00},
    '{OP_PROG, 1, 0, 0, 12'h006, 12'h007, 7'h05, 2'h0, 1, 8'h00},
    '{OP_RESET, 0, 0, 0, 12'h000, 12'h001, 7'h00, 2'h0, 0, 8'h00}};
  always #5 ref_clk = ~ref_clk;
  mpce_host uut (.ref_clk, .reset_n, .op_start, .op_kind, .op_multi, .op_final, .op_block_a,
    .op_block_b, .op_page, .op_column(14'h0000), .op_len, .wp_req, .op_ready,
    .op_done, .op_refused, .wr_data(8'h5A), .wr_valid(1'b1), .wr_ready(), .rd_data, .rd_valid,
    .rd_index, .status_byte, .any_fail, .cur_fail, .prev_fail, .dev_ready,
    .cache_ready, .not_protected, .status_incoherent, .prog_open, .copy_open,
    .nand_ce_n, .nand_cle, .nand_ale(), .nand_we_n, .nand_re_n, .nand_wp_n, .nand_io_out,
    .nand_io_oe, .nand_io_in, .ready_busy_out);
  mpce_flash_model dev (.nand_ce_n, .nand_cle, .nand_we_n, .nand_re_n, .nand_wp_n,
    .nand_io_out, .fail_inj, .nand_io_in, .ready_busy_out);
  // decoded status fields and session flags, packed for comparison
  assign fields = {not_protected, cache_ready, dev_ready, prev_fail, cur_fail, any_fail};
  assign sess = {5'h00, status_incoherent, prog_open, copy_open};
  // id bytes land by index as they stream out
  always @(posedge ref_clk) if (rd_valid === 1'b1) id_seen[rd_index] <= rd_data;
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // one request, then a bounded wait for its completion pulse
  task automatic run_op(input mpce_row_t r);
    int n;
    n = 0;
    while (op_ready !== 1'b1 && n < 100) begin @(negedge ref_clk); n++; end
    op_kind = r.k; op_multi = r.m; op_final = r.f; wp_req = r.w;
    op_block_a = r.a; op_block_b = r.b; op_page = r.p; fail_inj = r.fi;
    op_start = 1'b1;
    @(negedge ref_clk);
    op_start = 1'b0;
    n = 0;
    while (op_done !== 1'b1 && n < 3000) begin @(posedge ref_clk); #1; n++; end
    chk("done", 8'h01, {7'h00, op_done});
    @(negedge ref_clk);
  endtask : run_op
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  initial begin
    #200000;
    mismatches++;
    final_report();
  end
  initial begin
    repeat (16) @(negedge ref_clk);
    chk("idle pins", 8'h06, {5'h00, nand_ce_n, nand_we_n, nand_io_oe});
    reset_n = 1'b1;
    foreach (rows[i]) begin
      run_op(rows[i]);
      chk("refused", {7'h00, rows[i].rf}, {7'h00, op_refused});
      if (!rows[i].rf && rows[i].k != OP_RESET) begin
        chk("status", rows[i].st, status_byte);
        chk("fields", rows[i].st, fields);
      end
      // rows 2 to 5 run inside one open cached program session
      chk("sessions", {6'h00, 1'(i > 1 && i < 6), 1'b0}, sess);
      $display("row %0d done", i);
    end
    run_op('{OP_ID, 0, 0, 0, 12'h000, 12'h001, 7'h00, 2'h0, 0, 8'h00});
    for (int i = 0; i < 8; i++) chk("id byte", 8'hC0 + 8'(i), id_seen[i]);
    $display("id test done");
    wp_req = 1'b1;
    repeat (10) @(negedge ref_clk);
    chk("protect pin", 8'h00, {7'h00, nand_wp_n});
    wp_req = 1'b0;
    $display("protect test done");
    op_kind = OP_ERASE; op_multi = 1'b1; op_block_a = 12'h002; op_block_b = 12'h003;
    op_start = 1'b1;
    @(negedge ref_clk);
    op_start = 1'b0;
    repeat (30) @(negedge ref_clk);
    reset_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk("reset pins", 8'h06, {5'h00, nand_ce_n, nand_we_n, nand_io_oe});
    reset_n = 1'b1;
    run_op(rows[10]);
    chk("abort refused", 8'h00, {7'h00, op_refused});
    run_op(rows[7]);
    chk("status after abort", 8'hF0, status_byte);
    $display("reset test done");
    // copy with nothing altered: no data cycles, closed by 10h
    op_len = 14'h0000;
    run_op('{OP_COPY, 0, 1, 0, 12'h006, 12'h006, 7'h00, 2'h1, 0, 8'hE3});
    chk("copy refused", 8'h00, {7'h00, op_refused});
    chk("copy status", 8'hE3, status_byte);
    $display("copy test done");
    final_report();
  end
endmodule : tb
